// File: shared/pbs_pkg.sv
// Purpose: Shared constants and types for the bridge register bank and steering logic
// Assumes: Byte addressed register port, 32-bit data lanes, dword aligned storage
// Notes: Reset values are the loaded defaults of the bridge register image
package pbs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses as printed)
	localparam logic [11:0] OFS_VENDOR_CODE = 12'h000;
	localparam logic [11:0] OFS_DEVICE_CODE = 12'h002;
	localparam logic [11:0] OFS_COMMAND_WORD = 12'h004;
	localparam logic [11:0] OFS_STATUS_WORD = 12'h006;
	localparam logic [11:0] OFS_CLASS_AND_REVISION = 12'h008;
	localparam logic [11:0] OFS_HEADER_CONFIG = 12'h00c;
	localparam logic [11:0] OFS_BRIDGE_IO_WINDOW_BASE = 12'h010;
	localparam logic [11:0] OFS_CARRIER_WINDOW_BASE = 12'h014;
	localparam logic [11:0] OFS_MODULE_MEMORY_WINDOW_BASE = 12'h018;
	localparam logic [11:0] OFS_SUBSYSTEM_VENDOR_CODE = 12'h02c;
	localparam logic [11:0] OFS_SUBSYSTEM_CODE = 12'h02e;
	localparam logic [11:0] OFS_EXPANSION_ROM_BASE = 12'h030;
	localparam logic [11:0] OFS_BUS_PARAMETERS = 12'h03c;
	localparam logic [11:0] OFS_WINDOW0_MAPPING = 12'h040;
	localparam logic [11:0] OFS_WINDOW1_MAPPING = 12'h044;
	localparam logic [11:0] OFS_HOST_INTERRUPT_STATUS = 12'h048;
	localparam logic [11:0] OFS_HOST_INTERRUPT_CONFIG = 12'h04c;
	localparam logic [11:0] OFS_LOCAL_WINDOW0_BASE = 12'h054;
	localparam logic [11:0] OFS_LOCAL_WINDOW1_BASE = 12'h058;
	localparam logic [11:0] OFS_LOCAL_WINDOW0_MAPPING = 12'h05e;
	localparam logic [11:0] OFS_LOCAL_WINDOW1_MAPPING = 12'h062;
	localparam logic [11:0] OFS_LOCAL_WINDOW_SIZE = 12'h068;
	localparam logic [11:0] OFS_LOCAL_IO_BASE = 12'h06e;
	localparam logic [11:0] OFS_FIFO_CONFIG = 12'h070;
	localparam logic [11:0] OFS_FIFO_PRIORITY = 12'h072;
	localparam logic [11:0] OFS_FIFO_STATUS = 12'h074;
	localparam logic [11:0] OFS_LOCAL_INTERRUPT_STATUS = 12'h076;
	localparam logic [11:0] OFS_LOCAL_INTERRUPT_MASK = 12'h077;
	localparam logic [11:0] OFS_SYSTEM_CONTROL = 12'h078;
	localparam logic [11:0] OFS_INTERRUPT_STEERING = 12'hb28;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] RST_COMMAND_WORD = 16'h0000;
	localparam logic [15:0] RST_STATUS_WORD = 16'hf080;
	localparam logic [31:0] RST_CLASS_AND_REVISION = 32'h08800000;
	localparam logic [31:0] RST_HEADER_CONFIG = 32'h00000000;
	localparam logic [31:0] RST_BRIDGE_IO_WINDOW_BASE = 32'h00000000;
	localparam logic [31:0] RST_CARRIER_WINDOW_BASE = 32'h00000008;
	localparam logic [31:0] RST_MODULE_MEMORY_WINDOW_BASE = 32'h04000008;
	localparam logic [31:0] RST_EXPANSION_ROM_BASE = 32'h00000000;
	localparam logic [31:0] RST_BUS_PARAMETERS = 32'h00000100;
	localparam logic [31:0] RST_WINDOW0_MAPPING = 32'h00000003;
	localparam logic [31:0] RST_WINDOW1_MAPPING = 32'h04000063;
	localparam logic [31:0] RST_HOST_INTERRUPT_STATUS = 32'h00000000;
	localparam logic [31:0] RST_HOST_INTERRUPT_CONFIG = 32'h00020002;
	localparam logic [31:0] RST_LOCAL_WINDOW_BASE = 32'h00000000;
	localparam logic [15:0] RST_LOCAL_WINDOW_MAPPING = 16'h0006;
	localparam logic [31:0] RST_LOCAL_WINDOW_SIZE = 32'h00000000;
	localparam logic [15:0] RST_LOCAL_IO_BASE = 16'h0000;
	localparam logic [15:0] RST_FIFO_CONFIG = 16'h0a00;
	localparam logic [15:0] RST_FIFO_PRIORITY = 16'h0f0f;
	localparam logic [15:0] RST_FIFO_STATUS = 16'h0000;
	localparam logic [7:0] RST_LOCAL_INTERRUPT_BYTE = 8'h00;
	localparam logic [15:0] RST_SYSTEM_CONTROL = 16'hc400;

	////////////////////////////////////////////////////////////////////////////
	// Field positions and sizes
	localparam int BASE_LOW_BITS = 8;
	localparam logic [31:0] BASE_ADDR_MASK = 32'hffffff00;
	localparam logic [31:0] IRQ_LINE_MASK = 32'h000000ff;
	localparam int CMD_IO_BIT = 0;
	localparam int CMD_MEM_BIT = 1;
	localparam int STAT_CARRIER_BIT = 0;
	localparam int NUM_MODULES = 4;
	localparam int REQ_PER_MODULE = 2;
	localparam int STEER_BITS = NUM_MODULES * REQ_PER_MODULE;
	localparam logic [15:0] STEER_READ_MASK = 16'h01ff;
	localparam int DWORD_COUNT = 32;

	////////////////////////////////////////////////////////////////////////////
	// Host access request and address probe
	typedef struct packed {
		logic carrier_space;
		logic write;
		logic [11:0] addr;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} pbs_req_s;

	typedef struct packed {
		logic valid;
		logic is_mem;
		logic [31:0] addr;
	} pbs_probe_s;

endpackage

// File: hw/pbs_steer.sv
// Purpose: Interrupt steering capture for the module request lines
// Assumes: Request lines are level, active high, synchronous to mclk
// Notes: Bit order is first module request 0 up to fourth module request 1
`timescale 1ns/100ps
module pbs_steer #(
	parameter int WIDTH = pbs_pkg::STEER_BITS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Module request levels
	input wire logic [WIDTH-1:0] module_request,
	// Captured state
	output logic [WIDTH-1:0] steer_bits,
	output logic any_pending,
	output logic pending_rise
);

	logic prev_pending;

	////////////////////////////////////////////////////////////////////////////
	// Register the request levels, one bit per module request
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			steer_bits <= '0;
			any_pending <= 1'b0;
		end else begin
			steer_bits <= module_request;
			any_pending <= |module_request;
		end
	end

	// Edge of pending, so status is raised once per new burst of requests
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prev_pending <= 1'b0;
			pending_rise <= 1'b0;
		end else begin
			prev_pending <= any_pending;
			pending_rise <= any_pending & ~prev_pending;
		end
	end

endmodule // pbs_steer

// File: hw/pbs_regbank.sv
// Purpose: Host visible bridge register bank, window decode and carrier steering register
// Assumes: One access per request pulse, answered one cycle later; all inputs on mclk
// Notes: Storage is a dword array; 16 and 8 bit registers share dwords by byte lane
//
// Summary of operation
// [R1] Bridge register window base at 0x10, low 8 bits cleared for decode.
// [R2] Window at 0x14 decodes carrier space, never module memory accesses.
// [R3] Window at 0x18, low 8 bits masked, decodes module memory only.
// [R4] Low byte of bus parameters at 0x3c holds the assigned interrupt line.
// [R5] Steering register at carrier offset 0xb28 shows pending carrier interrupts.
// [R6] Steering bit 0 is first module request 0, bit 7 fourth module request 1.
// [R7] Software services steering bits ascending, clears sources, rereads until zero.
// [R8] Writing back the read status value at 0x48 clears the pending interrupt.
// [R9] Software leaves the base and bus parameter registers alone once assigned.
// [R10] Registers come out of reset with their loaded default values.
// [R11] Interrupt stays asserted while any steering or status bit is set.
`timescale 1ns/100ps
module pbs_regbank #(
	parameter logic [15:0] VENDOR_ID_VALUE = 16'h5a5a, // Arbitrary value
	parameter logic [15:0] DEVICE_ID_VALUE = 16'ha5a5, // Arbitrary value
	parameter logic [15:0] SUB_VENDOR_VALUE = 16'h1234, // Arbitrary value
	parameter logic [15:0] SUB_ID_VALUE = 16'h4321, // Arbitrary value
	parameter int CARRIER_WIN_BITS = 20,
	parameter int MEMORY_WIN_BITS = 25
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Host register access
	input wire logic acc_req,
	input wire pbs_pkg::pbs_req_s acc,
	output logic acc_ack,
	output logic [31:0] acc_rdata,
	// Host address probe for window decode
	input wire pbs_pkg::pbs_probe_s probe,
	output logic bridge_hit,
	output logic carrier_hit,
	output logic memory_hit,
	// Module interrupt requests
	input wire logic [pbs_pkg::STEER_BITS-1:0] module_request,
	// Host interrupt
	output logic int_req_n,
	output logic [7:0] interrupt_line
);

	////////////////////////////////////////////////////////////////////////////
	// Storage and decode helpers

	logic [31:0] regs [pbs_pkg::DWORD_COUNT];
	logic [31:0] int_status;
	logic [pbs_pkg::STEER_BITS-1:0] steer_bits;
	logic any_pending;
	logic pending_rise;
	logic [4:0] acc_index;
	logic [31:0] lane_mask;
	logic steer_sel;
	logic stat_sel;
	logic [31:0] next_rdata;

	// Dword index from a byte address
	function automatic logic [4:0] dword_of(input logic [11:0] a);
		return a[6:2];
	endfunction

	// Dword aligned byte address of a register
	function automatic logic [11:0] dword_base(input logic [11:0] a);
		return {a[11:2], 2'b00};
	endfunction

	// Reset image of each dword
	function automatic logic [31:0] reset_image(input logic [4:0] idx);
		logic [31:0] v;
		v = '0;
		unique case ({5'h00, idx, 2'b00})
			dword_base(pbs_pkg::OFS_VENDOR_CODE): v = {DEVICE_ID_VALUE, VENDOR_ID_VALUE};
			dword_base(pbs_pkg::OFS_COMMAND_WORD): v = {pbs_pkg::RST_STATUS_WORD, pbs_pkg::RST_COMMAND_WORD};
			pbs_pkg::OFS_CLASS_AND_REVISION: v = pbs_pkg::RST_CLASS_AND_REVISION;
			pbs_pkg::OFS_HEADER_CONFIG: v = pbs_pkg::RST_HEADER_CONFIG;
			pbs_pkg::OFS_BRIDGE_IO_WINDOW_BASE: v = pbs_pkg::RST_BRIDGE_IO_WINDOW_BASE;
			pbs_pkg::OFS_CARRIER_WINDOW_BASE: v = pbs_pkg::RST_CARRIER_WINDOW_BASE;
			pbs_pkg::OFS_MODULE_MEMORY_WINDOW_BASE: v = pbs_pkg::RST_MODULE_MEMORY_WINDOW_BASE;
			dword_base(pbs_pkg::OFS_SUBSYSTEM_VENDOR_CODE): v = {SUB_ID_VALUE, SUB_VENDOR_VALUE};
			pbs_pkg::OFS_EXPANSION_ROM_BASE: v = pbs_pkg::RST_EXPANSION_ROM_BASE;
			pbs_pkg::OFS_BUS_PARAMETERS: v = pbs_pkg::RST_BUS_PARAMETERS;
			pbs_pkg::OFS_WINDOW0_MAPPING: v = pbs_pkg::RST_WINDOW0_MAPPING;
			pbs_pkg::OFS_WINDOW1_MAPPING: v = pbs_pkg::RST_WINDOW1_MAPPING;
			pbs_pkg::OFS_HOST_INTERRUPT_CONFIG: v = pbs_pkg::RST_HOST_INTERRUPT_CONFIG;
			pbs_pkg::OFS_LOCAL_WINDOW0_BASE: v = pbs_pkg::RST_LOCAL_WINDOW_BASE;
			pbs_pkg::OFS_LOCAL_WINDOW1_BASE: v = pbs_pkg::RST_LOCAL_WINDOW_BASE;
			dword_base(pbs_pkg::OFS_LOCAL_WINDOW0_MAPPING): v = {pbs_pkg::RST_LOCAL_WINDOW_MAPPING, 16'h0000};
			dword_base(pbs_pkg::OFS_LOCAL_WINDOW1_MAPPING): v = {pbs_pkg::RST_LOCAL_WINDOW_MAPPING, 16'h0000};
			pbs_pkg::OFS_LOCAL_WINDOW_SIZE: v = pbs_pkg::RST_LOCAL_WINDOW_SIZE;
			dword_base(pbs_pkg::OFS_LOCAL_IO_BASE): v = {pbs_pkg::RST_LOCAL_IO_BASE, 16'h0000};
			pbs_pkg::OFS_FIFO_CONFIG: v = {pbs_pkg::RST_FIFO_PRIORITY, pbs_pkg::RST_FIFO_CONFIG};
			pbs_pkg::OFS_FIFO_STATUS: v = {pbs_pkg::RST_LOCAL_INTERRUPT_BYTE, pbs_pkg::RST_LOCAL_INTERRUPT_BYTE,
				pbs_pkg::RST_FIFO_STATUS};
			pbs_pkg::OFS_SYSTEM_CONTROL: v = {16'h0000, pbs_pkg::RST_SYSTEM_CONTROL};
			default: v = '0;
		endcase
		return v;
	endfunction

	// Bits that software may change in each dword; the rest read back fixed
	function automatic logic [31:0] write_mask(input logic [4:0] idx);
		logic [31:0] m;
		m = '0;
		unique case ({5'h00, idx, 2'b00})
			dword_base(pbs_pkg::OFS_COMMAND_WORD): m = 32'h0000ffff;
			pbs_pkg::OFS_HEADER_CONFIG: m = 32'hffffffff;
			pbs_pkg::OFS_BRIDGE_IO_WINDOW_BASE: m = pbs_pkg::BASE_ADDR_MASK;
			pbs_pkg::OFS_CARRIER_WINDOW_BASE: m = pbs_pkg::BASE_ADDR_MASK;
			pbs_pkg::OFS_MODULE_MEMORY_WINDOW_BASE: m = pbs_pkg::BASE_ADDR_MASK;
			pbs_pkg::OFS_EXPANSION_ROM_BASE: m = 32'hffffffff;
			pbs_pkg::OFS_BUS_PARAMETERS: m = pbs_pkg::IRQ_LINE_MASK;
			pbs_pkg::OFS_WINDOW0_MAPPING: m = 32'hffffffff;
			pbs_pkg::OFS_WINDOW1_MAPPING: m = 32'hffffffff;
			pbs_pkg::OFS_HOST_INTERRUPT_CONFIG: m = 32'hffffffff;
			pbs_pkg::OFS_LOCAL_WINDOW0_BASE: m = 32'hffffffff;
			pbs_pkg::OFS_LOCAL_WINDOW1_BASE: m = 32'hffffffff;
			dword_base(pbs_pkg::OFS_LOCAL_WINDOW0_MAPPING): m = 32'hffff0000;
			dword_base(pbs_pkg::OFS_LOCAL_WINDOW1_MAPPING): m = 32'hffff0000;
			pbs_pkg::OFS_LOCAL_WINDOW_SIZE: m = 32'hffffffff;
			dword_base(pbs_pkg::OFS_LOCAL_IO_BASE): m = 32'hffff0000;
			pbs_pkg::OFS_FIFO_CONFIG: m = 32'hffffffff;
			pbs_pkg::OFS_FIFO_STATUS: m = 32'hffff0000; // Fifo status half stays read only
			pbs_pkg::OFS_SYSTEM_CONTROL: m = 32'h0000ffff;
			default: m = '0;
		endcase
		return m;
	endfunction

	// Byte enables widened to a bit mask
	function automatic logic [31:0] lanes(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Window hit: compare address above the window size against the base
	function automatic logic window_hit(input logic [31:0] base, input logic [31:0] addr, input int size_bits);
		logic [31:0] keep;
		keep = ~((32'h00000001 << size_bits) - 32'h00000001);
		return ((addr & keep) == (base & pbs_pkg::BASE_ADDR_MASK & keep));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Steering capture

	// [R6] Steering bit order
	pbs_steer #(
		.WIDTH(pbs_pkg::STEER_BITS)
	) u_steer (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.module_request(module_request),
		.steer_bits(steer_bits),
		.any_pending(any_pending),
		.pending_rise(pending_rise)
	);

	////////////////////////////////////////////////////////////////////////////
	// Access decode

	// Address selects for the read and write paths; steer_sel is used by the read path only
	always_comb begin
		acc_index = dword_of(acc.addr);
		lane_mask = lanes(acc.byte_en);
		steer_sel = acc.carrier_space && (dword_base(acc.addr) == pbs_pkg::OFS_INTERRUPT_STEERING);
		stat_sel = !acc.carrier_space && (dword_base(acc.addr) == pbs_pkg::OFS_HOST_INTERRUPT_STATUS);
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file

	// [R10] Loaded defaults
	// Masked writes only; fixed bits keep their image even through a full write
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int i = 0; i < pbs_pkg::DWORD_COUNT; i++) begin
				regs[i] <= reset_image(5'(i));
			end
		end else if (acc_req && acc.write && !acc.carrier_space && !stat_sel
			&& acc.addr[11:7] == 5'h00) begin
			// [R1] Base writes keep low bits
			regs[acc_index] <= (regs[acc_index] & ~(write_mask(acc_index) & lane_mask))
				| (acc.wdata & write_mask(acc_index) & lane_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host interrupt status

	// [R8] Write back to clear
	// A new carrier event in the same cycle as the clear wins over the clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			int_status <= pbs_pkg::RST_HOST_INTERRUPT_STATUS;
		end else if (acc_req && acc.write && stat_sel) begin
			int_status <= (int_status & ~(acc.wdata & lane_mask))
				| (32'(pending_rise) << pbs_pkg::STAT_CARRIER_BIT);
		end else begin
			int_status <= int_status | (32'(pending_rise) << pbs_pkg::STAT_CARRIER_BIT);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path

	// Read data selection
	always_comb begin
		next_rdata = '0;
		if (acc.carrier_space) begin
			// [R5] Steering register read
			if (steer_sel) begin
				next_rdata = {16'h0000, 16'(steer_bits) & pbs_pkg::STEER_READ_MASK};
			end
		end else if (stat_sel) begin
			next_rdata = int_status;
		end else if (acc.addr[11:7] == 5'h00) begin
			next_rdata = regs[acc_index];
		end
		next_rdata = next_rdata & lane_mask; // Unselected lanes read zero
	end

	// Every request is answered one cycle later, reads and writes alike
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			acc_ack <= 1'b0;
			acc_rdata <= '0;
		end else begin
			acc_ack <= acc_req;
			if (acc_req && !acc.write) begin
				acc_rdata <= next_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Window decode

	// Registered hits; decoding is gated by the command word enables
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bridge_hit <= 1'b0;
			carrier_hit <= 1'b0;
			memory_hit <= 1'b0;
		end else begin
			// [R1] Bridge register window
			bridge_hit <= probe.valid && !probe.is_mem
				&& regs[dword_of(pbs_pkg::OFS_COMMAND_WORD)][pbs_pkg::CMD_IO_BIT]
				&& window_hit(regs[dword_of(pbs_pkg::OFS_BRIDGE_IO_WINDOW_BASE)], probe.addr,
					pbs_pkg::BASE_LOW_BITS);
			// [R2] Carrier window
			carrier_hit <= probe.valid && !probe.is_mem
				&& regs[dword_of(pbs_pkg::OFS_COMMAND_WORD)][pbs_pkg::CMD_MEM_BIT]
				&& window_hit(regs[dword_of(pbs_pkg::OFS_CARRIER_WINDOW_BASE)], probe.addr,
					CARRIER_WIN_BITS);
			// [R3] Module memory window
			memory_hit <= probe.valid && probe.is_mem
				&& regs[dword_of(pbs_pkg::OFS_COMMAND_WORD)][pbs_pkg::CMD_MEM_BIT]
				&& window_hit(regs[dword_of(pbs_pkg::OFS_MODULE_MEMORY_WINDOW_BASE)], probe.addr,
					MEMORY_WIN_BITS);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host interrupt output

	// [R11] Hold interrupt while pending
	// Level from both sources, so a missed edge never strands a request
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			int_req_n <= 1'b1;
		end else begin
			int_req_n <= ~(any_pending | (|int_status));
		end
	end

	// [R4] Assigned interrupt line
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			interrupt_line <= pbs_pkg::RST_BUS_PARAMETERS[7:0];
		end else begin
			interrupt_line <= regs[dword_of(pbs_pkg::OFS_BUS_PARAMETERS)][7:0];
		end
	end

	// [R9] Base registers stay writable; software is trusted not to move them

endmodule // pbs_regbank

// File: tb/pbs_regbank_chk.sv
// Purpose: Port checker for the bridge register bank
// Assumes: One mclk domain, sys_rst synchronous active high
// Notes: Attached to every pbs_regbank by the bind at the foot
`timescale 1ns/100ps
module pbs_regbank_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Host access
	input wire logic acc_req,
	input wire pbs_pkg::pbs_req_s acc,
	input wire logic acc_ack,
	input wire logic [31:0] acc_rdata,
	// Probe and hits
	input wire pbs_pkg::pbs_probe_s probe,
	input wire logic bridge_hit,
	input wire logic carrier_hit,
	input wire logic memory_hit,
	// Interrupts
	input wire logic [7:0] module_request,
	input wire logic int_req_n,
	input wire logic [7:0] interrupt_line
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////
	// Decoded access kinds
	logic steer_rd;
	logic line_wr;
	assign steer_rd = acc_req && !acc.write && acc.carrier_space && acc.addr == pbs_pkg::OFS_INTERRUPT_STEERING
		&& acc.byte_en == 4'hf;
	assign line_wr = acc_req && acc.write && !acc.carrier_space && acc.addr == pbs_pkg::OFS_BUS_PARAMETERS
		&& acc.byte_en[0];

	// Write-back steps: sources quiet, then status written with the event bit
	sequence s_quiet;
		(module_request == 8'h00)[*5];
	endsequence
	sequence s_wb_clear;
		acc_req && acc.write && !acc.carrier_space && acc.addr == pbs_pkg::OFS_HOST_INTERRUPT_STATUS
			&& acc.byte_en == 4'hf && acc.wdata[0];
	endsequence

	////////////////////////////////////////////////////////////////////////////
	a_ack_follows: assert property (acc_req |=> acc_ack)
		else $error("ack missing one cycle after request");
	a_ack_lone: assert property (!acc_req |=> !acc_ack)
		else $error("ack without request");
	a_steer_read: assert property (steer_rd && module_request == $past(module_request)
		|=> acc_rdata == {24'h0, $past(module_request)})
		else $error("steering read does not match requests");
	a_line_follows: assert property (line_wr |-> ##2 interrupt_line == $past(acc.wdata[7:0], 2))
		else $error("interrupt line not updated");
	a_int_raise: assert property ((module_request != 8'h00)[*2] |=> !int_req_n)
		else $error("interrupt not asserted");
	a_int_release: assert property ($rose(int_req_n) |-> $past(module_request, 2) == 8'h00)
		else $error("interrupt released while a request was pending");
	a_wb_release: assert property (s_quiet ##0 s_wb_clear |-> ##2 int_req_n)
		else $error("write-back did not release interrupt");
	a_mem_not_carrier: assert property (probe.valid && probe.is_mem |=> !bridge_hit && !carrier_hit)
		else $error("memory access hit an io window");
	a_io_not_mem: assert property (probe.valid && !probe.is_mem |=> !memory_hit)
		else $error("io access hit the memory window");
	a_idle_no_hit: assert property (!probe.valid |=> !(bridge_hit || carrier_hit || memory_hit))
		else $error("hit without probe");
endmodule // pbs_regbank_chk

bind pbs_regbank pbs_regbank_chk i_chk (.mclk(mclk), .sys_rst(sys_rst), .acc_req(acc_req), .acc(acc),
	.acc_ack(acc_ack), .acc_rdata(acc_rdata), .probe(probe), .bridge_hit(bridge_hit), .carrier_hit(carrier_hit),
	.memory_hit(memory_hit), .module_request(module_request), .int_req_n(int_req_n),
	.interrupt_line(interrupt_line));

// File: tb/pbs_host_model.sv
// Purpose: Host software model with module request sources
// Assumes: Tasks entered just after a rising edge of mclk
// Notes: Logs handler reads and service order for the bench
`timescale 1ns/100ps
module pbs_host_model (
	// Clock
	input wire logic mclk,
	// Register access
	output pbs_pkg::pbs_req_s acc,
	output logic acc_req,
	input wire logic acc_ack,
	input wire logic [31:0] acc_rdata,
	// Address probe
	output pbs_pkg::pbs_probe_s probe,
	// Module sources, cleared by the handler
	output logic [7:0] module_request
);
	int served[$];
	logic [31:0] log_rd[$];

	// Idle values at time zero
	initial begin
		acc_req = 1'b0;
		acc = '0;
		probe = '0;
		module_request = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// One access: one-cycle request, bounded wait for the answer
	task automatic xfer(input logic cs, input logic wr, input logic [11:0] a, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		acc_req <= 1'b1;
		acc <= '{carrier_space: cs, write: wr, addr: a, byte_en: be, wdata: wd};
		@(posedge mclk);
		acc_req <= 1'b0;
		// Released lines carry no stale value
		acc <= ~acc;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (acc_ack !== 1'b1 && n < 4);
		rd = acc_rdata;
	endtask

	// Probe one address; hits are read right after return
	task automatic probe_at(input logic m, input logic [31:0] a);
		probe <= '{valid: 1'b1, is_mem: m, addr: a};
		@(posedge mclk);
		probe <= '{valid: 1'b0, is_mem: ~m, addr: ~a};
		@(posedge mclk);
	endtask

	task automatic service();
		logic [31:0] v;
		logic [31:0] s;
		int i;
		int guard;
		xfer(1'b1, 1'b0, pbs_pkg::OFS_INTERRUPT_STEERING, 4'hf, 32'h0, v);
		log_rd.push_back(v);
		v = v & 32'h1ff;
		guard = 0;
		while (v !== 32'h0 && guard < 16) begin
			i = 0;
			while (v[i] !== 1'b1 && i < 8) i++;
			served.push_back(i);
			module_request[i] <= 1'b0;
			// Let the cleared level reach the steering bits
			repeat (2) @(posedge mclk);
			xfer(1'b1, 1'b0, pbs_pkg::OFS_INTERRUPT_STEERING, 4'hf, 32'h0, v);
			log_rd.push_back(v);
			v = v & 32'h1ff;
			guard++;
		end
		xfer(1'b0, 1'b0, pbs_pkg::OFS_HOST_INTERRUPT_STATUS, 4'hf, 32'h0, s);
		log_rd.push_back(s);
		xfer(1'b0, 1'b1, pbs_pkg::OFS_HOST_INTERRUPT_STATUS, 4'hf, s, v);
	endtask
endmodule // pbs_host_model

// File: tb/pbs_regbank_tb_top.sv
// Purpose: Self-checking bench for the bridge register bank
// Assumes: Host model drives all accesses, probes and sources
// Notes: Expected values come from the register table and window rules
`timescale 1ns/100ps
module pbs_regbank_tb_top;
	localparam logic [15:0] VEN = 16'h5a5a; // Arbitrary value
	localparam logic [15:0] DEV = 16'ha5a5; // Arbitrary value
	localparam logic [15:0] SVEN = 16'h1234; // Arbitrary value
	localparam logic [15:0] SDEV = 16'h4321; // Arbitrary value
	logic mclk, sys_rst, acc_req, acc_ack, bridge_hit, carrier_hit, memory_hit, int_req_n, m;
	logic [31:0] acc_rdata, v, io_b, cw_b, mw_b, pa;
	logic [7:0] module_request, interrupt_line, src, exp;
	pbs_pkg::pbs_req_s acc;
	pbs_pkg::pbs_probe_s probe;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed;
	int n;
	logic [11:0] rst_a [18] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h02c,
		12'h03c, 12'h040, 12'h044, 12'h048, 12'h04c, 12'h05c, 12'h060, 12'h070, 12'h078, 12'h080};
	logic [31:0] rst_v [18] = '{{DEV, VEN}, 32'hf0800000, 32'h08800000, 32'h0, 32'h0, 32'h8, 32'h04000008,
		{SDEV, SVEN}, 32'h100, 32'h3, 32'h04000063, 32'h0, 32'h00020002, 32'h00060000, 32'h00060000,
		32'h0f0f0a00, 32'h0000c400, 32'h0};

	pbs_regbank #(.VENDOR_ID_VALUE(VEN), .DEVICE_ID_VALUE(DEV), .SUB_VENDOR_VALUE(SVEN), .SUB_ID_VALUE(SDEV)) i_dut (
		.mclk(mclk), .sys_rst(sys_rst), .acc_req(acc_req), .acc(acc), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
		.probe(probe), .bridge_hit(bridge_hit), .carrier_hit(carrier_hit), .memory_hit(memory_hit),
		.module_request(module_request), .int_req_n(int_req_n), .interrupt_line(interrupt_line));
	pbs_host_model i_host (.mclk(mclk), .acc(acc), .acc_req(acc_req), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
		.probe(probe), .module_request(module_request));

	////////////////////////////////////////////////////////////////////////////
	// Compare tasks and closing
	task automatic check32(input logic [31:0] got, input logic [31:0] want, input string what);
		comparisons++;
		if (got !== want) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, want);
		end
	endtask
	task automatic check1(input logic got, input logic want, input string what);
		check32({31'h0, got}, {31'h0, want}, what);
	endtask
	task automatic report_and_stop();
		if (mismatches == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Clock and hang guard; the run needs well under this many cycles
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 23;
		sys_rst = 1'b1;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		// Loaded defaults, unmapped places read zero
		foreach (rst_a[k]) begin
			i_host.xfer(1'b0, 1'b0, rst_a[k], 4'hf, 32'h0, v);
			check32(v, rst_v[k], "default");
		end
		i_host.xfer(1'b1, 1'b0, 12'h000, 4'hf, 32'h0, v);
		check32(v, 32'h0, "carrier unmapped");
		check1(interrupt_line == 8'h00, 1'b1, "line reset");
		// Assigned once, never moved
		// Firmware assigns bases; only bits 31:8 take
		io_b = $random(seed);
		cw_b = $random(seed);
		mw_b = $random(seed);
		i_host.xfer(1'b0, 1'b1, 12'h010, 4'hf, io_b, v);
		i_host.xfer(1'b0, 1'b1, 12'h014, 4'hf, cw_b, v);
		i_host.xfer(1'b0, 1'b1, 12'h018, 4'hf, mw_b, v);
		i_host.xfer(1'b0, 1'b1, 12'h03c, 4'hf, 32'hffffffff, v);
		i_host.xfer(1'b0, 1'b0, 12'h010, 4'hf, 32'h0, v);
		check32(v, io_b & 32'hffffff00, "io base");
		i_host.xfer(1'b0, 1'b0, 12'h014, 4'hf, 32'h0, v);
		check32(v, (cw_b & 32'hffffff00) | 32'h8, "carrier base");
		i_host.xfer(1'b0, 1'b0, 12'h018, 4'hf, 32'h0, v);
		check32(v, (mw_b & 32'hffffff00) | 32'h8, "memory base");
		i_host.xfer(1'b0, 1'b0, 12'h03c, 4'hf, 32'h0, v);
		check32(v, 32'h1ff, "bus parameters");
		check1(interrupt_line == 8'hff, 1'b1, "line");
		// Every command mode, probes aimed at each window
		for (int c = 0; c < 4; c++) begin
			i_host.xfer(1'b0, 1'b1, 12'h004, 4'h3, 32'(c), v);
			for (int k = 0; k < 12; k++) begin
				m = k[0];
				pa = $random(seed);
				case (k % 3)
					0: pa[31:8] = io_b[31:8];
					1: pa[31:20] = cw_b[31:20];
					default: pa[31:25] = mw_b[31:25];
				endcase
				i_host.probe_at(m, pa);
				check1(bridge_hit, !m && c[0] && pa[31:8] == io_b[31:8], "bridge hit");
				check1(carrier_hit, !m && c[1] && pa[31:20] == cw_b[31:20], "carrier hit");
				check1(memory_hit, m && c[1] && pa[31:25] == mw_b[31:25], "memory hit");
			end
		end
		// Each request alone, then random groups
		for (int k = 0; k < 12; k++) begin
			src = (k < 8) ? 8'h01 << k : 8'($random(seed)) | 8'h01;
			i_host.module_request <= src;
			repeat (3) @(posedge mclk);
			check1(int_req_n, 1'b0, "int asserted");
			i_host.served.delete();
			i_host.log_rd.delete();
			i_host.service();
			exp = src;
			check32(i_host.log_rd[0], {24'h0, exp}, "steering");
			n = 0;
			for (int b = 0; b < 8; b++) begin
				if (src[b]) begin
					check32(i_host.served[n], b, "order");
					exp[b] = 1'b0;
					n++;
					check32(i_host.log_rd[n], {24'h0, exp}, "steering");
				end
			end
			check32(i_host.log_rd[n + 1], 32'h1, "status");
			repeat (2) @(posedge mclk);
			check1(int_req_n, 1'b1, "int released");
			i_host.xfer(1'b0, 1'b0, 12'h048, 4'hf, 32'h0, v);
			check32(v, 32'h0, "status cleared");
		end
		report_and_stop();
	end
endmodule // pbs_regbank_tb_top
